// ---- exec_subset_pkg.sv ----
// Shared constants, instruction encoding and register map of the execution subset.
package exec_subset_pkg;

    // Widths and depths.
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int REG_AW = 6;
    localparam int IO_AW = 4;
    localparam int IMM_W = 10;
    localparam int DATA_REGS = 64;
    localparam int IO_REGS = 16;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PW = 3;
    localparam int STACK_LW = 4;
    localparam int BUS_AW = 8;

    // Lowest page address that the page read accepts.
    localparam logic [IO_AW-1:0] IO_READ_MIN = 4'h5;

    // Register map (plain port, one byte each).
    localparam logic [BUS_AW-1:0] DATA_BASE = 8'h00;
    localparam logic [BUS_AW-1:0] DATA_LAST = 8'h3f;
    localparam logic [BUS_AW-1:0] ACC_OFF = 8'h40;
    localparam logic [BUS_AW-1:0] STATUS_OFF = 8'h41;
    localparam logic [BUS_AW-1:0] PC_LOW_OFF = 8'h42;
    localparam logic [BUS_AW-1:0] PC_HIGH_OFF = 8'h43;
    localparam logic [BUS_AW-1:0] PCHB_OFF = 8'h44;
    localparam logic [BUS_AW-1:0] TABLE_HIGH_POINTER_OFF = 8'h45;
    localparam logic [BUS_AW-1:0] STACK_LVL_OFF = 8'h46;
    localparam logic [BUS_AW-1:0] IO_BASE = 8'h50;
    localparam logic [BUS_AW-1:0] IO_LAST = 8'h5f;

    // Field positions of the status register.
    localparam int ZERO_BIT = 0;
    localparam int CARRY_BIT = 1;
    localparam int GIE_BIT = 2;

    // Reset values.
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [1:0] HIGH_RESET = 2'h0;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_INTERRUPTS_OFF,
        OP_INTERRUPTS_ON,
        OP_PAGED_JUMP,
        OP_COMPUTED_JUMP,
        OP_ADD_ONE_REG,
        OP_ADD_ONE_SKIP_ZERO,
        OP_OR_ACC_REG,
        OP_OR_ACC_IMMEDIATE,
        OP_IO_PAGE_WRITE,
        OP_IO_PAGE_READ,
        OP_LONG_SUBROUTINE_CALL,
        OP_LONG_JUMP,
        OP_LOAD_IMMEDIATE_ACC,
        OP_STORE_ACC_REG,
        OP_COPY_REG,
        OP_INTERRUPT_EXIT,
        OP_SUBROUTINE_EXIT,
        OP_ROTATE_LEFT_CARRY
    } opcode_t;

    // One decoded instruction: operation, destination select, register or page address, immediate.
    typedef struct packed {
        opcode_t op;
        logic destReg;
        logic [REG_AW-1:0] regAddr;
        logic [IMM_W-1:0] imm;
    } instr_t;

    // Result of the arithmetic unit.
    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic zero;
        logic carry;
    } alu_out_t;

endpackage

// ---- exec_alu.sv ----
// Combinational result unit for increment, inclusive OR, copy and rotate.
`timescale 1ns/100ps
module exec_alu
    import exec_subset_pkg::*;
(
    // Operation and operands
    input opcode_t op,
    input logic [DATA_W-1:0] acc,
    input logic [DATA_W-1:0] regVal,
    input logic [DATA_W-1:0] imm,
    input logic carryIn,
    // Result
    output alu_out_t res
);

    always_comb begin
        res.value = regVal;
        res.carry = carryIn;
        case (op)
            OP_ADD_ONE_REG, OP_ADD_ONE_SKIP_ZERO: begin
                res.value = regVal + 8'h01;
            end
            OP_OR_ACC_REG: begin
                res.value = acc | regVal;
            end
            OP_OR_ACC_IMMEDIATE: begin
                res.value = acc | imm;
            end
            OP_ROTATE_LEFT_CARRY: begin
                res.value = {regVal[6:0], carryIn};
                res.carry = regVal[7];
            end
            default: begin
                res.value = regVal;
            end
        endcase
        res.zero = (res.value == 8'h00);
    end

endmodule // exec_alu

// ---- call_stack.sv ----
// Eight-level return address stack with push and pop.
`timescale 1ns/100ps
module call_stack
    import exec_subset_pkg::*;
(
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Control
    input logic push,
    input logic pop,
    input logic [PC_W-1:0] pushData,
    // State
    output logic [PC_W-1:0] top,
    output logic [STACK_LW-1:0] level
);

    logic [PC_W-1:0] entry_q [STACK_DEPTH];
    logic [STACK_PW-1:0] ptr_q;
    logic [STACK_LW-1:0] level_q;
    logic [STACK_PW-1:0] topIdx;

    assign topIdx = ptr_q - 3'h1;
    assign top = entry_q[topIdx];
    assign level = level_q;

    // The pointer wraps, so a ninth push overwrites the oldest entry.
    genvar i;
    generate
        for (i = 0; i < STACK_DEPTH; i++) begin : gEntry
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    entry_q[i] <= PC_RESET;
                end else if (push && ptr_q == STACK_PW'(i)) begin
                    entry_q[i] <= pushData;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ptr_q <= 3'h0;
            level_q <= 4'h0;
        end else if (push) begin
            ptr_q <= ptr_q + 3'h1;
            if (level_q != 4'h8) begin
                level_q <= level_q + 4'h1;
            end
        end else if (pop) begin
            ptr_q <= topIdx;
            if (level_q != 4'h0) begin
                level_q <= level_q - 4'h1;
            end
        end
    end

endmodule // call_stack

// ---- mcu_exec_subset.sv ----
// Execution unit for the interrupt, jump, call, return, increment, OR, move and rotate instructions.
//
// What this block does
// - interrupts_off clears global_irq_enable, no flag change, one cycle.
// - interrupts_on sets global_irq_enable, no flag change, one cycle.
// - paged_jump loads 9-bit immediate into PC[8:0], buffer bit 1 into PC[9].
// - computed_jump loads pointer bits 1:0 and accumulator into PC, two cycles.
// - Destination select 0 writes the accumulator, 1 writes the source register.
// - add_one_reg writes register plus one, updates zero flag, one cycle.
// - add_one_skip_zero increments without flags; zero result discards the next instruction.
// - or_acc_reg ORs accumulator with register into destination, updates zero.
// - or_acc_immediate ORs accumulator with immediate into accumulator, updates zero.
// - io_page_write copies accumulator into page register 0 to 15, no flags.
// - io_page_read copies page register 5 to 15 into accumulator, no flags.
// - long_subroutine_call pushes next address and loads 10-bit immediate, two cycles.
// - long_jump loads 10-bit immediate into PC without the buffer, two cycles.
// - load_immediate_acc places the immediate into the accumulator, flags unchanged.
// - store_acc_reg writes accumulator into data register 0 to 63, no flags.
// - copy_reg moves register to destination and updates the zero flag.
// - interrupt_exit pops PC from the stack and sets global_irq_enable, two cycles.
// - subroutine_exit pops PC from the stack, flags untouched, two cycles.
// - rotate_left_carry shifts left through carry into the destination.
`timescale 1ns/100ps
module mcu_exec_subset
    import exec_subset_pkg::*;
(
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Instruction stream
    input logic instrValid,
    input instr_t instr,
    output logic instrReady,
    // Core state
    output logic [PC_W-1:0] pcOut,
    output logic globalIrqEnable,
    output logic zeroFlag,
    output logic carryFlag,
    output logic [DATA_W-1:0] accOut,
    // Register port
    input logic [BUS_AW-1:0] busAddr,
    input logic [DATA_W-1:0] busWdata,
    input logic busWrite,
    input logic busRead,
    output logic [DATA_W-1:0] busRdata
);

    logic ready_q;
    logic flush_q;
    logic [PC_W-1:0] pc_q;
    logic [DATA_W-1:0] acc_q;
    logic zero_q;
    logic carry_q;
    logic gie_q;
    logic [1:0] pchb_q;
    logic [1:0] table_high_pointer_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] dataReg_q [DATA_REGS];
    logic [DATA_W-1:0] ioReg_q [IO_REGS];

    logic fire;
    logic exec;
    logic twoCycle;
    logic writesDest;
    logic updatesZero;
    logic toReg;
    logic toAcc;
    logic skipTaken;
    logic stackPush;
    logic stackPop;
    logic [PC_W-1:0] pcNext;
    logic [PC_W-1:0] pcPlusOne;
    logic [PC_W-1:0] stackTop;
    logic [STACK_LW-1:0] stackLevel;
    logic [DATA_W-1:0] regVal;
    logic [IO_AW-1:0] ioAddr;
    logic [DATA_W-1:0] busIdx;
    alu_out_t alu;

    assign instrReady = ready_q;
    assign pcOut = pc_q;
    assign globalIrqEnable = gie_q;
    assign zeroFlag = zero_q;
    assign carryFlag = carry_q;
    assign accOut = acc_q;
    assign busRdata = rdata_q;

    // An instruction is taken when offered while ready; a flushed one only advances the PC.
    assign fire = instrValid && ready_q;
    assign exec = fire && !flush_q;
    assign regVal = dataReg_q[instr.regAddr];
    assign ioAddr = instr.regAddr[IO_AW-1:0];
    assign pcPlusOne = pc_q + 10'h001;

    always_comb begin
        twoCycle = 1'b0;
        writesDest = 1'b0;
        updatesZero = 1'b0;
        stackPush = 1'b0;
        stackPop = 1'b0;
        case (instr.op)
            OP_COMPUTED_JUMP, OP_LONG_JUMP: begin
                twoCycle = 1'b1;
            end
            OP_LONG_SUBROUTINE_CALL: begin
                twoCycle = 1'b1;
                stackPush = exec;
            end
            OP_INTERRUPT_EXIT, OP_SUBROUTINE_EXIT: begin
                twoCycle = 1'b1;
                stackPop = exec;
            end
            OP_ADD_ONE_REG, OP_OR_ACC_REG, OP_COPY_REG: begin
                writesDest = 1'b1;
                updatesZero = 1'b1;
            end
            OP_ADD_ONE_SKIP_ZERO, OP_ROTATE_LEFT_CARRY: begin
                writesDest = 1'b1;
            end
            OP_OR_ACC_IMMEDIATE: begin
                updatesZero = 1'b1;
            end
            default: begin
                twoCycle = 1'b0;
            end
        endcase
    end

    assign toReg = exec && writesDest && instr.destReg;
    assign toAcc = exec && writesDest && !instr.destReg;
    assign skipTaken = exec && instr.op == OP_ADD_ONE_SKIP_ZERO && alu.zero;

    exec_alu uAlu (
        .op(instr.op),
        .acc(acc_q),
        .regVal(regVal),
        .imm(instr.imm[DATA_W-1:0]),
        .carryIn(carry_q),
        .res(alu)
    );

    call_stack uStack (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(stackPush),
        .pop(stackPop),
        .pushData(pcPlusOne),
        .top(stackTop),
        .level(stackLevel)
    );

    // Next program counter.
    always_comb begin
        pcNext = pcPlusOne;
        if (exec) begin
            case (instr.op)
                OP_PAGED_JUMP: begin
                    pcNext = {pchb_q[1], instr.imm[8:0]};
                end
                OP_COMPUTED_JUMP: begin
                    pcNext = {table_high_pointer_q, acc_q};
                end
                OP_LONG_SUBROUTINE_CALL, OP_LONG_JUMP: begin
                    pcNext = instr.imm;
                end
                OP_INTERRUPT_EXIT, OP_SUBROUTINE_EXIT: begin
                    pcNext = stackTop;
                end
                default: begin
                    pcNext = pcPlusOne;
                end
            endcase
        end
    end

    // Two-cycle instructions hold off the next instruction for one bubble cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ready_q <= 1'b1;
        end else begin
            ready_q <= !(exec && twoCycle);
        end
    end

    // The instruction after a taken skip is already fetched; it is discarded as a no-operation.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flush_q <= 1'b0;
        end else if (fire) begin
            flush_q <= skipTaken;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_q <= PC_RESET;
        end else if (fire) begin
            pc_q <= pcNext;
        end
    end

    // Accumulator; an executing instruction wins over a register-port write in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q <= DATA_RESET;
        end else if (toAcc) begin
            acc_q <= alu.value;
        end else if (exec && instr.op == OP_OR_ACC_IMMEDIATE) begin
            acc_q <= alu.value;
        end else if (exec && instr.op == OP_LOAD_IMMEDIATE_ACC) begin
            acc_q <= instr.imm[DATA_W-1:0];
        end else if (exec && instr.op == OP_IO_PAGE_READ && ioAddr >= IO_READ_MIN) begin
            acc_q <= ioReg_q[ioAddr];
        end else if (busWrite && busAddr == ACC_OFF) begin
            acc_q <= busWdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            zero_q <= FLAG_RESET;
        end else if (exec && updatesZero) begin
            zero_q <= alu.zero;
        end else if (busWrite && busAddr == STATUS_OFF) begin
            zero_q <= busWdata[ZERO_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            carry_q <= FLAG_RESET;
        end else if (exec && instr.op == OP_ROTATE_LEFT_CARRY) begin
            carry_q <= alu.carry;
        end else if (busWrite && busAddr == STATUS_OFF) begin
            carry_q <= busWdata[CARRY_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gie_q <= FLAG_RESET;
        end else if (exec && instr.op == OP_INTERRUPTS_OFF) begin
            gie_q <= 1'b0;
        end else if (exec && (instr.op == OP_INTERRUPTS_ON || instr.op == OP_INTERRUPT_EXIT)) begin
            gie_q <= 1'b1;
        end else if (busWrite && busAddr == STATUS_OFF) begin
            gie_q <= busWdata[GIE_BIT];
        end
    end

    // Page-select high bits are loaded only from the register port.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pchb_q <= HIGH_RESET;
            table_high_pointer_q <= HIGH_RESET;
        end else if (busWrite && busAddr == PCHB_OFF) begin
            pchb_q <= busWdata[1:0];
        end else if (busWrite && busAddr == TABLE_HIGH_POINTER_OFF) begin
            table_high_pointer_q <= busWdata[1:0];
        end
    end

    // Data registers and page registers, one flip-flop byte per entry.
    genvar i;
    generate
        for (i = 0; i < DATA_REGS; i++) begin : gData
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    dataReg_q[i] <= DATA_RESET;
                end else if (toReg && instr.regAddr == REG_AW'(i)) begin
                    dataReg_q[i] <= alu.value;
                end else if (exec && instr.op == OP_STORE_ACC_REG && instr.regAddr == REG_AW'(i)) begin
                    dataReg_q[i] <= acc_q;
                end else if (busWrite && busAddr == DATA_BASE + BUS_AW'(i)) begin
                    dataReg_q[i] <= busWdata;
                end
            end
        end
        for (i = 0; i < IO_REGS; i++) begin : gIo
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    ioReg_q[i] <= DATA_RESET;
                end else if (exec && instr.op == OP_IO_PAGE_WRITE && ioAddr == IO_AW'(i)) begin
                    ioReg_q[i] <= acc_q;
                end else if (busWrite && busAddr == IO_BASE + BUS_AW'(i)) begin
                    ioReg_q[i] <= busWdata;
                end
            end
        end
    endgenerate

    // Read data stand for exactly the cycle after the read strobe; unmapped reads give zero.
    assign busIdx = busAddr - IO_BASE;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= DATA_RESET;
        end else if (!busRead) begin
            rdata_q <= DATA_RESET;
        end else if (busAddr <= DATA_LAST) begin
            rdata_q <= dataReg_q[busAddr[REG_AW-1:0]];
        end else if (busAddr == ACC_OFF) begin
            rdata_q <= acc_q;
        end else if (busAddr == STATUS_OFF) begin
            rdata_q <= {5'h00, gie_q, carry_q, zero_q};
        end else if (busAddr == PC_LOW_OFF) begin
            rdata_q <= pc_q[7:0];
        end else if (busAddr == PC_HIGH_OFF) begin
            rdata_q <= {6'h00, pc_q[9:8]};
        end else if (busAddr == PCHB_OFF) begin
            rdata_q <= {6'h00, pchb_q};
        end else if (busAddr == TABLE_HIGH_POINTER_OFF) begin
            rdata_q <= {6'h00, table_high_pointer_q};
        end else if (busAddr == STACK_LVL_OFF) begin
            rdata_q <= {4'h0, stackLevel};
        end else if (busAddr >= IO_BASE && busAddr <= IO_LAST) begin
            rdata_q <= ioReg_q[busIdx[IO_AW-1:0]];
        end else begin
            rdata_q <= DATA_RESET;
        end
    end

endmodule // mcu_exec_subset

// ---- mcu_exec_subset_asserts.sv ----
// Port-level concurrent checks for the execution unit.
`timescale 1ns/100ps
module mcu_exec_subset_asserts
    import exec_subset_pkg::*;
(
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Instruction stream
    input logic instrValid,
    input instr_t instr,
    input logic instrReady,
    // Core state
    input logic [PC_W-1:0] pcOut,
    input logic globalIrqEnable,
    input logic zeroFlag,
    input logic carryFlag,
    input logic [DATA_W-1:0] accOut,
    // Register port
    input logic [BUS_AW-1:0] busAddr,
    input logic [DATA_W-1:0] busWdata,
    input logic busWrite,
    input logic busRead,
    input logic [DATA_W-1:0] busRdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic take;
    logic skipSeen_q;
    logic clean;
    assign take = instrValid && instrReady;
    // An instruction taken after a skip may be discarded, and a bus write may collide, so both are left out.
    assign clean = take && !skipSeen_q && !busWrite;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            skipSeen_q <= 1'b0;
        end else if (take) begin
            skipSeen_q <= (instr.op == OP_ADD_ONE_SKIP_ZERO);
        end
    end
    property p_off; clean && instr.op == OP_INTERRUPTS_OFF |=> !globalIrqEnable && instrReady; endproperty
    a_off: assert property (p_off) else $error("interrupt enable not cleared");
    property p_on; clean && instr.op == OP_INTERRUPTS_ON |=> globalIrqEnable && zeroFlag == $past(zeroFlag); endproperty
    a_on: assert property (p_on) else $error("interrupt enable not set");
    property p_paged; clean && instr.op == OP_PAGED_JUMP |=> pcOut[8:0] == $past(instr.imm[8:0]); endproperty
    a_paged: assert property (p_paged) else $error("paged jump target wrong");
    property p_comp; clean && instr.op == OP_COMPUTED_JUMP |=> (pcOut[7:0] == $past(accOut) && !instrReady) ##1 instrReady;
    endproperty
    a_comp: assert property (p_comp) else $error("computed jump wrong");
    property p_inc; clean && instr.op == OP_ADD_ONE_REG && !instr.destReg |=> zeroFlag == (accOut == 8'h00); endproperty
    a_inc: assert property (p_inc) else $error("add one zero flag wrong");
    property p_skip; clean && instr.op == OP_ADD_ONE_SKIP_ZERO |=> $stable(zeroFlag) && $stable(carryFlag); endproperty
    a_skip: assert property (p_skip) else $error("skip increment changed a flag");
    property p_orimm; clean && instr.op == OP_OR_ACC_IMMEDIATE
        |=> accOut == ($past(accOut) | $past(instr.imm[7:0])) && zeroFlag == (accOut == 8'h00); endproperty
    a_orimm: assert property (p_orimm) else $error("immediate or wrong");
    property p_call; clean && instr.op == OP_LONG_SUBROUTINE_CALL |=> (pcOut == $past(instr.imm) && !instrReady) ##1 instrReady;
    endproperty
    a_call: assert property (p_call) else $error("call target or timing wrong");
    property p_ljmp; clean && instr.op == OP_LONG_JUMP |=> pcOut == $past(instr.imm) ##1 instrReady; endproperty
    a_ljmp: assert property (p_ljmp) else $error("long jump wrong");
    property p_iexit; clean && instr.op == OP_INTERRUPT_EXIT |=> globalIrqEnable && !instrReady; endproperty
    a_iexit: assert property (p_iexit) else $error("interrupt return wrong");
    property p_sexit; clean && instr.op == OP_SUBROUTINE_EXIT |=> $stable(globalIrqEnable) && !instrReady; endproperty
    a_sexit: assert property (p_sexit) else $error("subroutine return wrong");
    property p_rot; clean && instr.op == OP_ROTATE_LEFT_CARRY && !instr.destReg
        |=> accOut[0] == $past(carryFlag) && $stable(zeroFlag); endproperty
    a_rot: assert property (p_rot) else $error("rotate carry in wrong");
    property p_nop; clean && instr.op == OP_NOP |=> pcOut == $past(pcOut) + 10'h001 && $stable(accOut); endproperty
    a_nop: assert property (p_nop) else $error("no operation changed state");
    c_skip: cover property (clean && instr.op == OP_ADD_ONE_SKIP_ZERO);
    c_call: cover property (clean && instr.op == OP_LONG_SUBROUTINE_CALL);
    c_comp: cover property (clean && instr.op == OP_COMPUTED_JUMP);
endmodule // mcu_exec_subset_asserts

bind mcu_exec_subset mcu_exec_subset_asserts u_asserts (.clk_sys(clk_sys), .rst_n(rst_n), .instrValid(instrValid),
    .instr(instr), .instrReady(instrReady), .pcOut(pcOut), .globalIrqEnable(globalIrqEnable), .zeroFlag(zeroFlag),
    .carryFlag(carryFlag), .accOut(accOut), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
    .busRead(busRead), .busRdata(busRdata));

// ---- mcu_exec_subset_bench.sv ----
// Self-checking bench for the execution unit with a reference model.
`timescale 1ns/100ps
module mcu_exec_subset_bench
    import exec_subset_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic instrValid = 1'b0;
    instr_t instr = '0;
    logic instrReady;
    logic [PC_W-1:0] pcOut;
    logic globalIrqEnable, zeroFlag, carryFlag;
    logic [DATA_W-1:0] accOut, busRdata;
    logic [BUS_AW-1:0] busAddr = 8'h00;
    logic [DATA_W-1:0] busWdata = 8'h00;
    logic busWrite = 1'b0;
    logic busRead = 1'b0;
    int failCount = 0, compares = 0, seed = 13173;
    int acc, z, c, global_irq_enable, pc, pchb, table_high_pointer, skipPend, i, n;
    int regs[64];
    int page[16];
    int stk[$];
    opcode_t op;

    mcu_exec_subset DUT (.clk_sys(clk_sys), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
        .instrReady(instrReady), .pcOut(pcOut), .globalIrqEnable(globalIrqEnable), .zeroFlag(zeroFlag),
        .carryFlag(carryFlag), .accOut(accOut), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
        .busRead(busRead), .busRdata(busRdata));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        if (failCount == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmpState;
        chk(pcOut, 10'(pc));
        chk(10'(accOut), 10'(acc));
        chk(10'(zeroFlag), 10'(z));
        chk(10'(carryFlag), 10'(c));
        chk(10'(globalIrqEnable), 10'(global_irq_enable));
    endtask

    function automatic int rdExp(input logic [7:0] a);
        if (a <= DATA_LAST) return regs[a];
        if (a >= IO_BASE && a <= IO_LAST) return page[a[3:0]];
        case (a)
            ACC_OFF: return acc;
            STATUS_OFF: return z + 2 * c + 4 * global_irq_enable;
            PC_LOW_OFF: return pc % 256;
            PC_HIGH_OFF: return pc / 256;
            PCHB_OFF: return pchb;
            TABLE_HIGH_POINTER_OFF: return table_high_pointer;
            STACK_LVL_OFF: return stk.size();
            default: return 0;
        endcase
    endfunction

    // Bus tasks start at a rising edge and leave a gap cycle so no strobe is assigned twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        busWrite <= 1'b1;
        busAddr <= a;
        busWdata <= dt;
        @(posedge clk_sys);
        busWrite <= 1'b0;
        if (a <= DATA_LAST) regs[a] = dt;
        if (a >= IO_BASE && a <= IO_LAST) page[a[3:0]] = dt;
        if (a == ACC_OFF) acc = dt;
        if (a == PCHB_OFF) pchb = dt % 4;
        if (a == TABLE_HIGH_POINTER_OFF) table_high_pointer = dt % 4;
        if (a == STATUS_OFF) begin
            z = dt[0];
            c = dt[1];
            global_irq_enable = dt[2];
        end
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a);
        busRead <= 1'b1;
        busAddr <= a;
        @(posedge clk_sys);
        busRead <= 1'b0;
        @(negedge clk_sys);
        chk(10'(busRdata), 10'(rdExp(a)));
        @(negedge clk_sys);
        chk(10'(busRdata), 10'h000);
        @(posedge clk_sys);
    endtask

    task automatic model(input opcode_t o, input logic d, input logic [5:0] r, input logic [9:0] imm);
        int res;
        int rv;
        rv = regs[r];
        res = -1;
        pc = (pc + 1) % 1024;
        if (skipPend) begin
            skipPend = 0;
            return;
        end
        case (o)
            OP_INTERRUPTS_OFF: global_irq_enable = 0;
            OP_INTERRUPTS_ON: global_irq_enable = 1;
            OP_PAGED_JUMP: pc = (pchb / 2) * 512 + imm[8:0];
            OP_COMPUTED_JUMP: pc = table_high_pointer * 256 + acc;
            OP_ADD_ONE_REG: begin
                res = (rv + 1) % 256;
                z = (res == 0);
            end
            OP_ADD_ONE_SKIP_ZERO: begin
                res = (rv + 1) % 256;
                skipPend = (res == 0);
            end
            OP_OR_ACC_REG: begin
                res = acc | rv;
                z = (res == 0);
            end
            OP_OR_ACC_IMMEDIATE: begin
                acc = acc | imm[7:0];
                z = (acc == 0);
            end
            OP_IO_PAGE_WRITE: page[r[3:0]] = acc;
            OP_IO_PAGE_READ: if (r[3:0] >= IO_READ_MIN) acc = page[r[3:0]];
            OP_LONG_SUBROUTINE_CALL: begin
                stk.push_back(pc);
                pc = imm;
            end
            OP_LONG_JUMP: pc = imm;
            OP_LOAD_IMMEDIATE_ACC: acc = imm[7:0];
            OP_STORE_ACC_REG: regs[r] = acc;
            OP_COPY_REG: begin
                res = rv;
                z = (rv == 0);
            end
            OP_INTERRUPT_EXIT: begin
                pc = stk.pop_back();
                global_irq_enable = 1;
            end
            OP_SUBROUTINE_EXIT: pc = stk.pop_back();
            OP_ROTATE_LEFT_CARRY: begin
                res = (rv * 2) % 256 + c;
                c = rv / 128;
            end
            default: ;
        endcase
        if (res >= 0 && d) regs[r] = res;
        if (res >= 0 && !d) acc = res;
    endtask

    // Offers one instruction, checks the previous result, and returns at the edge that took it.
    task automatic exec(input opcode_t o, input logic d, input logic [5:0] r, input logic [9:0] imm);
        int k;
        k = 0;
        instrValid <= 1'b1;
        instr <= '{op: o, destReg: d, regAddr: r, imm: imm};
        @(negedge clk_sys);
        cmpState;
        while (instrReady !== 1'b1 && k < 4) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 4) failCount++;
        @(posedge clk_sys);
        model(o, d, r, imm);
    endtask

    task automatic settle;
        instrValid <= 1'b0;
        @(negedge clk_sys);
        cmpState;
        @(posedge clk_sys);
    endtask

    initial begin
        #200000;
        failCount++;
        test_done;
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        for (i = 8'h40; i < 8'h48; i++) rd(8'(i));
        wr(PC_LOW_OFF, 8'h12);
        rd(PC_LOW_OFF);
        rd(8'h60);
        for (i = 0; i < 64; i++) wr(8'(i), 8'($random(seed)));
        wr(8'h05, 8'hff);
        wr(PCHB_OFF, 8'h02);
        wr(TABLE_HIGH_POINTER_OFF, 8'h03);
        exec(OP_ADD_ONE_SKIP_ZERO, 1'b1, 6'h05, 10'h000);
        exec(OP_LOAD_IMMEDIATE_ACC, 1'b0, 6'h00, 10'h077);
        exec(OP_PAGED_JUMP, 1'b0, 6'h00, 10'h1ff);
        exec(OP_COMPUTED_JUMP, 1'b0, 6'h00, 10'h000);
        exec(OP_IO_PAGE_WRITE, 1'b0, 6'h03, 10'h000);
        exec(OP_IO_PAGE_READ, 1'b0, 6'h03, 10'h000);
        exec(OP_LONG_SUBROUTINE_CALL, 1'b0, 6'h00, 10'h3ff);
        exec(OP_INTERRUPT_EXIT, 1'b0, 6'h00, 10'h000);
        for (n = 0; n < 400; n++) begin
            op = opcode_t'(5'($unsigned($random(seed)) % 19));
            if (op == OP_LONG_SUBROUTINE_CALL && stk.size() >= STACK_DEPTH) op = OP_NOP;
            if ((op == OP_INTERRUPT_EXIT || op == OP_SUBROUTINE_EXIT) && stk.size() == 0) op = OP_NOP;
            exec(op, 1'($random(seed)), 6'($random(seed)), 10'($random(seed)));
            if (n % 32 == 31) begin
                settle;
                wr(8'(STATUS_OFF + n % 5), 8'($random(seed)));
                rd(STACK_LVL_OFF);
            end
        end
        settle;
        for (i = 0; i < 8'h60; i++) rd(8'(i));
        test_done;
    end
endmodule // mcu_exec_subset_bench
